//--- ppac_ctrl.sv
// APB control block: prescale, alignment, pair join and stop controls
//
// Behaviour
// - Bits 6..4 of prescale register set clock B rate, for every channel.
// - Bits 2..0 of prescale register set clock A rate, for every channel.
// - Code n divides bus clock by two to the n, up to 128.
// - Prescale writes accepted anytime; a glitchy pulse may follow.
// - One alignment bit per channel; set means center, clear means left.
// - Bits of absent channels ignore writes and read zero.
// - Control bits 7..4 join pairs 6/7, 4/5, 2/3, 0/1 into 16 bits.
// - In a joined pair the even channel is the high byte.
// - Joined pair uses odd pin and odd clock, polarity, enable, align.
// - Join bits of absent pairs ignore writes and read zero.
// - Wait-stop bit set in wait mode gates the prescaler input clock.
// - Freeze-stop bit set in freeze mode gates prescaler; channels on clock A or B halt, scaled inputs pass.
// - Registers stay accessible in freeze; clock resumes on bit clear.
// - Each channel picks clock A, B, scaled A or scaled B.
// - Joined pair ignores even enable and keeps even output off.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module ppac_ctrl
    import ppac_pkg::*;
#(
    parameter int NUM_CH = 8
)(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wait_mode,
    input  wire logic        freeze_mode,
    input  wire logic        sa_tick,
    input  wire logic        sb_tick,
    output logic             clk_a_tick,
    output logic             clk_b_tick,
    output logic      [7:0]  chan_tick,
    output logic      [7:0]  chan_enable,
    output logic      [7:0]  chan_polarity,
    output logic      [7:0]  chan_center,
    output logic      [7:0]  chan_high_byte,
    output logic      [3:0]  join_pair
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check and channel masks

    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
        $error("NUM_CH must be 1 to 8");
    end

    localparam logic [7:0] CH_MASK = 8'((9'h001 << NUM_CH) - 9'h001);

    // Pair k exists only when both of its channels exist
    localparam logic [7:0] JOIN_MASK = {CH_MASK[7], CH_MASK[5],
                                        CH_MASK[3], CH_MASK[1], 4'h0};

    localparam logic [7:0] CTL_MASK = JOIN_MASK | CTL_STOP_MASK;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [5:0] idx;
    logic       wr_en;
    logic       mapped;

    // Index from the word address; upper byte lanes ignored
    function automatic logic is_mapped(input logic [5:0] i);
        return i <= IDX_AB_SOURCE;
    endfunction : is_mapped

    assign idx     = paddr[7:2];
    assign mapped  = is_mapped(idx);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en   = psel & penable & pwrite & mapped;

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] enable_r,  enable_nxt;
    logic [7:0] pol_r,     pol_nxt;
    logic [7:0] scaled_r,  scaled_nxt;
    logic [7:0] pre_r,     pre_nxt;
    logic [7:0] cae_r,     cae_nxt;
    logic [7:0] ctl_r,     ctl_nxt;
    logic [7:0] ab_r,      ab_nxt;

    // Next register values; absent bits never store
    always_comb begin
        enable_nxt = enable_r;
        pol_nxt    = pol_r;
        scaled_nxt = scaled_r;
        pre_nxt    = pre_r;
        cae_nxt    = cae_r;
        ctl_nxt    = ctl_r;
        ab_nxt     = ab_r;
        if (wr_en) begin
            case (idx)
                IDX_CHAN_ENABLE:  enable_nxt = pwdata[7:0] & CH_MASK;
                IDX_POLARITY:     pol_nxt    = pwdata[7:0] & CH_MASK;
                IDX_SCALED_SEL:   scaled_nxt = pwdata[7:0] & CH_MASK;
                IDX_PRESCALE:     pre_nxt    = pwdata[7:0] & PRE_MASK;
                IDX_CENTER_ALIGN: cae_nxt    = pwdata[7:0] & CH_MASK;
                IDX_MODULE_CTRL:  ctl_nxt    = pwdata[7:0] & CTL_MASK;
                IDX_AB_SOURCE:    ab_nxt     = pwdata[7:0] & CH_MASK;
                default: begin
                end
            endcase
        end
    end

    // Register the file
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_r <= RST_REG8;
            pol_r    <= RST_REG8;
            scaled_r <= RST_REG8;
            pre_r    <= RST_REG8;
            cae_r    <= RST_REG8;
            ctl_r    <= RST_REG8;
            ab_r     <= RST_REG8;
        end else begin
            enable_r <= enable_nxt;
            pol_r    <= pol_nxt;
            scaled_r <= scaled_nxt;
            pre_r    <= pre_nxt;
            cae_r    <= cae_nxt;
            ctl_r    <= ctl_nxt;
            ab_r     <= ab_nxt;
        end
    end

    // Read mux; registers readable in every mode
    // access kept during freeze
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (idx)
                IDX_CHAN_ENABLE:  prdata[7:0] = enable_r;
                IDX_POLARITY:     prdata[7:0] = pol_r;
                IDX_SCALED_SEL:   prdata[7:0] = scaled_r;
                IDX_PRESCALE:     prdata[7:0] = pre_r;
                IDX_CENTER_ALIGN: prdata[7:0] = cae_r;
                IDX_MODULE_CTRL:  prdata[7:0] = ctl_r;
                IDX_AB_SOURCE:    prdata[7:0] = ab_r;
                default:          prdata      = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and low-power stop

    ppac_presc_if pif ();

    logic stop_wait;
    logic stop_frz;

    assign stop_wait = ctl_r[CTL_STOP_WAIT] & wait_mode;
    // resumes when bit or mode clears
    assign stop_frz  = ctl_r[CTL_STOP_FREEZE] & freeze_mode;
    assign pif.run   = ~(stop_wait | stop_frz);
    assign pif.sel_a = pre_r[PRE_A_LSB +: 3];
    assign pif.sel_b = pre_r[PRE_B_LSB +: 3];

    ppac_prescaler u_presc (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pif     (pif)
    );

    assign clk_a_tick = pif.tick_a;
    assign clk_b_tick = pif.tick_b;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel source, join and output controls

    assign join_pair = ctl_r[CTL_JOIN_LSB +: 4];

    // Clock A when the select bit differs from the group's zero sense
    function automatic logic picks_a(input logic ab, input int ch);
        return ab ^ AB_A_ON_ZERO[ch];
    endfunction : picks_a

    for (genvar c = 0; c < 8; c++) begin : g_ch
        localparam int ODD = c | 1;
        logic use_a;
        logic src;
        logic joined;
        assign joined = join_pair[c/2];
        assign use_a = picks_a(ab_r[ODD], ODD);
        assign src   = scaled_r[ODD] ? (use_a ? sa_tick : sb_tick)
                                     : (use_a ? pif.tick_a : pif.tick_b);
        if (c % 2 == 0) begin : g_even
            assign chan_tick[c]      = CH_MASK[c] & (joined ? 1'b0 :
                                       (scaled_r[c] ?
                                       (picks_a(ab_r[c], c) ?
                                        sa_tick : sb_tick) :
                                       (picks_a(ab_r[c], c) ?
                                        pif.tick_a : pif.tick_b)));
            assign chan_enable[c]    = enable_r[c] & ~joined;
            assign chan_polarity[c]  = joined ? pol_r[ODD] : pol_r[c];
            assign chan_center[c]    = joined ? cae_r[ODD] : cae_r[c];
            assign chan_high_byte[c] = joined;
        end else begin : g_odd
            assign chan_tick[c]      = CH_MASK[c] & src;
            assign chan_enable[c]    = enable_r[c];
            assign chan_polarity[c]  = pol_r[c];
            assign chan_center[c]    = cae_r[c];
            assign chan_high_byte[c] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_wait_gate: assert property (@(posedge clk_sys) disable iff (rst)
        wait_mode && ctl_r[CTL_STOP_WAIT] |-> !clk_a_tick && !clk_b_tick)
        else $error("prescaler ran while stopped in wait");
    a_freeze_gate: assert property (@(posedge clk_sys) disable iff (rst)
        freeze_mode && ctl_r[CTL_STOP_FREEZE] |-> chan_tick == 8'h00)
        else $error("channel clocks ran in freeze stop");
    a_prescale_write: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && idx == IDX_PRESCALE |=> pre_r == ($past(pwdata[7:0]) & 8'h77))
        else $error("prescale write not stored");
    a_align_absent: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && idx == IDX_CENTER_ALIGN
        |=> cae_r == ($past(pwdata[7:0]) & CH_MASK))
        else $error("alignment write mishandled");
    a_join_even_off: assert property (@(posedge clk_sys) disable iff (rst)
        join_pair[0] |-> !chan_enable[0] && chan_tick[0] == 1'b0)
        else $error("even half of joined pair active");
    a_join_align: assert property (@(posedge clk_sys) disable iff (rst)
        join_pair[1] |-> chan_center[2] == cae_r[3]
                      && chan_polarity[2] == pol_r[3])
        else $error("joined pair not steered by odd channel");
    a_join_stores: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && idx == IDX_MODULE_CTRL
        |=> join_pair == ($past(pwdata[7:4]) & JOIN_MASK[7:4]))
        else $error("join bits not stored as written");

endmodule : ppac_ctrl

//--- ppac_pkg.sv
// Constants and register layout for the prescale, align and join control
package ppac_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CHAN_ENABLE  = 6'h00;
    localparam logic [5:0] IDX_POLARITY     = 6'h01;
    localparam logic [5:0] IDX_SCALED_SEL   = 6'h02;
    localparam logic [5:0] IDX_PRESCALE     = 6'h03;
    localparam logic [5:0] IDX_CENTER_ALIGN = 6'h04;
    localparam logic [5:0] IDX_MODULE_CTRL  = 6'h05;
    localparam logic [5:0] IDX_AB_SOURCE    = 6'h06;

    // Values after reset
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [6:0] RST_CNT  = 7'h00;

    // Field positions in the prescale register
    localparam int PRE_A_LSB = 0;
    localparam int PRE_B_LSB = 4;
    localparam logic [7:0] PRE_MASK = 8'h77;

    // Field positions in the module control register
    localparam int CTL_JOIN_LSB    = 4;
    localparam int CTL_STOP_WAIT   = 3;
    localparam int CTL_STOP_FREEZE = 2;
    localparam logic [7:0] CTL_STOP_MASK = 8'h0c;

    // Largest prescale divisor is two to this power
    localparam int PRE_CNT_W = 7;

    // Channels whose A/B select bit reads zero for clock A
    localparam logic [7:0] AB_A_ON_ZERO = 8'h33;

endpackage : ppac_pkg

//--- ppac_presc_if.sv
// Carrier between the control block and the prescaler
`timescale 1ns/1ps
interface ppac_presc_if;
    logic       run;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic       tick_a;
    logic       tick_b;

    modport ctrl  (output run, output sel_a, output sel_b,
                   input tick_a, input tick_b);
    modport presc (input run, input sel_a, input sel_b,
                   output tick_a, output tick_b);
endinterface : ppac_presc_if

//--- ppac_prescaler.sv
// Free-running prescaler producing clock A and clock B enable pulses
`timescale 1ns/1ps
module ppac_prescaler
    import ppac_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    ppac_presc_if.presc pif
);

    logic [PRE_CNT_W-1:0] cnt_r;
    logic [PRE_CNT_W-1:0] cnt_nxt;

    // Low bits all ones means the divided period ends this cycle
    function automatic logic tick_of(input logic [PRE_CNT_W-1:0] c,
                                     input logic [2:0] sel);
        logic [PRE_CNT_W-1:0] m;
        m = PRE_CNT_W'((8'h01 << sel) - 8'h01);
        return (c & m) == m;
    endfunction : tick_of

    // Counter advances only while the input clock is not stopped
    always_comb begin
        cnt_nxt = cnt_r;
        if (pif.run) begin
            cnt_nxt = cnt_r + PRE_CNT_W'(1);
        end
    end

    // Register the counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= RST_CNT;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign pif.tick_a = pif.run & tick_of(cnt_r, pif.sel_a);
    assign pif.tick_b = pif.run & tick_of(cnt_r, pif.sel_b);

    // Stopped input clock yields no pulses
    a_stop_no_tick: assert property (@(posedge clk_sys) disable iff (rst)
        !pif.run |-> !pif.tick_a && !pif.tick_b)
        else $error("prescaler pulsed while stopped");
    // Code zero gives the undivided clock
    a_code0_every: assert property (@(posedge clk_sys) disable iff (rst)
        pif.run && pif.sel_a == 3'h0 |-> pif.tick_a)
        else $error("code zero did not pulse every cycle");
    // Code one pulses every second running cycle
    a_code1_spacing: assert property (@(posedge clk_sys) disable iff (rst)
        pif.run && pif.sel_b == 3'h1 && pif.tick_b
        ##1 pif.run && pif.sel_b == 3'h1 |-> !pif.tick_b)
        else $error("divide by two pulsed twice in a row");

endmodule : ppac_prescaler

//--- ppac_load_model.sv
// Load model that tallies the clock enable pulses reaching each channel
`timescale 1ns/1ps
module ppac_load_model (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             clr,
    input  wire logic [7:0]       chan_tick,
    output logic      [7:0][15:0] cnt
);
    // Per-channel pulse tally, cleared on request
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (rst || clr) begin
                cnt[i] <= 16'h0000;
            end else begin
                cnt[i] <= cnt[i] + 16'(chan_tick[i]);
            end
        end
    end
endmodule : ppac_load_model

//--- pwm_prescale_align_concat_ctrl_tb_top.sv
// Self-checking bench for the prescale, align and join control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    fail_count++; $display("Error %s exp %h got %h", nm, exp, got); end end
module pwm_prescale_align_concat_ctrl_tb_top;
    import ppac_pkg::*;
    logic             clk_sys = 0, rst = 1, psel = 0, penable = 0;
    logic             pwrite = 0, wait_mode = 0, freeze_mode = 0, clr = 0;
    logic             sa_tick = 0, sb_tick = 0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0, prdata;
    logic             pready, pslverr, tick_a, tick_b;
    logic [7:0]       chan_tick, chan_en, chan_pol, chan_ctr, chan_hi;
    logic [3:0]       join_pair;
    logic [7:0][15:0] cnt;
    int               fail_count = 0, cmp_count = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, device with channels 6 and 7 absent, and load model
    always #20 clk_sys = ~clk_sys;
    ppac_ctrl #(.NUM_CH(6)) ppac_ctrl_i (.clk_sys(clk_sys), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wait_mode(wait_mode),
        .freeze_mode(freeze_mode), .sa_tick(sa_tick), .sb_tick(sb_tick),
        .clk_a_tick(tick_a), .clk_b_tick(tick_b), .chan_tick(chan_tick),
        .chan_enable(chan_en), .chan_polarity(chan_pol),
        .chan_center(chan_ctr), .chan_high_byte(chan_hi),
        .join_pair(join_pair));
    ppac_load_model ppac_load_model_i (.clk_sys(clk_sys), .rst(rst),
        .clr(clr), .chan_tick(chan_tick), .cnt(cnt));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    // One APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [5:0] i,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {i, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wreg(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, i, d, r, e);
    endtask : wreg
    task automatic rreg(input logic [5:0] i, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, i, 8'h00, r, e);
        `CHK("read", exp, r)
    endtask : rreg
    // Count pulses over 256 cycles; tally read at the next edge, pre-update
    task automatic measure();
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (257) @(posedge clk_sys);
    endtask : measure
    ////////////////////////////////////////////////////////////////////////
    // Reset values and refused unmapped access
    task automatic t_reset_map();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 7; i++) rreg(6'(i), 32'h0);
        `CHK("tick_a", 1'b1, tick_a)
        `CHK("tick_b", 1'b1, tick_b)
        apb(1'b1, 6'h07, 8'hff, r, e);
        `CHK("slverr", 1'b1, e)
        apb(1'b0, 6'h07, 8'h00, r, e);
        `CHK("unmapped", 32'h0, r)
    endtask : t_reset_map
    // Every prescale code on A and B, written while running
    task automatic t_prescale();
        wreg(IDX_AB_SOURCE, 8'h08);
        for (int n = 0; n < 8; n++) begin
            wreg(IDX_PRESCALE, 8'(((7 - n) << 4) | n));
            measure();
            `CHK("clk_a", 16'(256 >> n), cnt[0])
            `CHK("clk_b", 16'(256 >> (7 - n)), cnt[2])
            `CHK("ab_sel", 16'(256 >> n), cnt[3])
        end
        wreg(IDX_PRESCALE, 8'hff);
        rreg(IDX_PRESCALE, 32'h77);
        wreg(IDX_PRESCALE, 8'h00);
        wreg(IDX_AB_SOURCE, 8'h00);
    endtask : t_prescale
    // Join pairs, alignment, absent channels
    task automatic t_join();
        // set join and align while channels are disabled
        wreg(IDX_MODULE_CTRL, 8'hf0);
        wreg(IDX_CENTER_ALIGN, 8'he0);
        wreg(IDX_POLARITY, 8'haa);
        wreg(IDX_CHAN_ENABLE, 8'hff);
        rreg(IDX_MODULE_CTRL, 32'h70);
        rreg(IDX_CHAN_ENABLE, 32'h3f);
        rreg(IDX_CENTER_ALIGN, 32'h20);
        `CHK("join", 4'h7, join_pair)
        `CHK("hi_byte", 8'h15, chan_hi)
        `CHK("enable", 8'h2a, chan_en)
        `CHK("polarity", 8'h3f, chan_pol)
        `CHK("center", 8'h30, chan_ctr)
        measure();
        for (int i = 0; i < 8; i++) begin
            `CHK("tick", (i < 6 && i % 2) ? 16'd256 : 16'd0, cnt[i])
        end
        wreg(IDX_CHAN_ENABLE, 8'h00);
        wreg(IDX_MODULE_CTRL, 8'h00);
    endtask : t_join
    // Stop in freeze and wait modes, and resume
    task automatic t_stop();
        wreg(IDX_MODULE_CTRL, 8'h04);
        freeze_mode <= 1'b1;
        measure();
        `CHK("frz_stop", 16'd0, cnt[1])
        `CHK("tick_a_frz", 1'b0, tick_a)
        rreg(IDX_MODULE_CTRL, 32'h04);
        wreg(IDX_MODULE_CTRL, 8'h08);
        measure();
        `CHK("frz_run", 16'd256, cnt[1])
        @(posedge clk_sys);
        freeze_mode <= 1'b0;
        wait_mode   <= 1'b1;
        measure();
        `CHK("wait_stop", 16'd0, cnt[1])
        wreg(IDX_MODULE_CTRL, 8'h04);
        measure();
        `CHK("wait_run", 16'd256, cnt[1])
        wait_mode <= 1'b0;
    endtask : t_stop
    // Scaled sources steered by the A/B select in both channel groups
    task automatic t_scaled();
        wreg(IDX_SCALED_SEL, 8'h0f);
        wreg(IDX_AB_SOURCE, 8'h06);
        sa_tick <= 1'b1;
        measure();
        `CHK("sa_ch0", 16'd256, cnt[0])
        `CHK("sb_ch1", 16'd0, cnt[1])
        `CHK("sa_ch2", 16'd256, cnt[2])
        `CHK("sb_ch3", 16'd0, cnt[3])
        sa_tick <= 1'b0;
        wreg(IDX_SCALED_SEL, 8'h00);
        wreg(IDX_AB_SOURCE, 8'h00);
    endtask : t_scaled
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_map();
        t_prescale();
        t_join();
        t_scaled();
        t_stop();
        results();
    end
endmodule : pwm_prescale_align_concat_ctrl_tb_top
